// ===== include/srs_pkg.sv
// Purpose: Shared constants for the supervisor reset and strap logic.
// Assumes: 100 MHz pclk, APB register access with 32-bit data.
// Notes:   Register words are aligned; unlisted bits read as zero.
package srs_pkg;
	localparam int unsigned CLK_FREQ_HZ      = 100_000_000;
	localparam int unsigned HOLD_TIME_MS     = 180;
	localparam int unsigned HOLD_CYCLES      = HOLD_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int          HOLD_CNT_W       = 25;

	localparam int          ADDR_W           = 4;
	localparam logic [3:0]  OFF_CONFIG       = 4'h0;
	localparam logic [3:0]  OFF_TEST1        = 4'h4;
	localparam logic [3:0]  OFF_ANALOG_CFG   = 4'h8;
	localparam logic [3:0]  OFF_STATUS       = 4'hc;

	localparam int          CFG_INT_EN_BIT   = 1;
	localparam int          TEST1_PWM_INV_BIT = 1;
	localparam int          ACFG_VREF_2V5_BIT = 0;
	localparam int          ACFG_D2_ANALOG_BIT = 1;

	localparam int          ST_STBY_REL_BIT  = 0;
	localparam int          ST_MAIN_REL_BIT  = 1;
	localparam int          ST_TEST_MODE_BIT = 2;
	localparam int          ST_EXT_RST_BIT   = 3;
	localparam int          ST_STBY_OK_BIT   = 4;
	localparam int          ST_MAIN_OK_BIT   = 5;

	localparam logic [31:0] CONFIG_RST       = 32'h0000_0000;
	localparam logic [31:0] TEST1_RST        = 32'h0000_0000;
	localparam logic [31:0] ANALOG_CFG_RST   = 32'h0000_0000;
	localparam logic        PWM_LEVEL_RST    = 1'b1;

	typedef enum logic [1:0] {
		SRS_STRAP_WAIT = 2'b00,
		SRS_STRAP_NORM = 2'b01,
		SRS_STRAP_TEST = 2'b11
	} srs_strap_t;
endpackage : srs_pkg

// ===== verilog/srs_hold_timer.sv
// Purpose: Reset hold timer that releases after a run of good cycles.
// Assumes: run is synchronous to pclk.
// Notes:   Any drop of run clears the count and reasserts at once.
`timescale 1ns/100ps
`default_nettype none
module srs_hold_timer #(
	parameter int unsigned HOLD_CYCLES = srs_pkg::HOLD_CYCLES,
	parameter int          CNT_W       = srs_pkg::HOLD_CNT_W
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	input  wire logic run,
	output var  logic release_reg
);
	logic [CNT_W-1:0] cnt_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg     <= '0;
			release_reg <= 1'b0;
		end else if (ce) begin
			// (RULE_14) restart on dropout
			if (!run) begin
				cnt_reg     <= '0;
				release_reg <= 1'b0;
			end else if (!release_reg) begin
				if (cnt_reg == CNT_W'(HOLD_CYCLES - 1)) begin
					release_reg <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + CNT_W'(1);
				end
			end
		end
	end
endmodule : srs_hold_timer
`default_nettype wire

// ===== verilog/srs_supervisor.sv
// Purpose: Power-on resets, pin options and test strap behind an APB slave.
// Assumes: Rail comparator flags and pins are synchronous to pclk.
// Notes:   Open-drain pins use an active-low output enable.
//
// Overview of operation
// (RULE_01) Interrupt pin drives only when config bit 1 set; off after reset.
// (RULE_02) Fan pulse-width pin is high after reset, full duty for NMOS stage.
// (RULE_03) Test register 1 bit 1 inverts fan pulse-width pin polarity.
// (RULE_04) Standby reset held low while standby rail is below threshold.
// (RULE_05) Standby reset held about 180 ms after standby rail recovers.
// (RULE_06) Main reset held low while main rail is below threshold.
// (RULE_07) Main reset held about 180 ms after main rail recovers.
// (RULE_08) Main reset releases 180 ms after standby reset when standby rises first.
// (RULE_09) Main reset pin also accepts an external active-low reset request.
// (RULE_10) Reference output selectable 1.8 V or 2.5 V; 1.8 V after reset.
// (RULE_11) First diode cathode sampled at power-on; high enters test mode.
// (RULE_12) Second diode pins selectable as diode input or analog inputs.
// (RULE_13) In test mode the tree result appears on the address-select pin.
// (RULE_14) A rail dropout during hold reasserts reset and restarts the count.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module srs_supervisor #(
	parameter int unsigned HOLD_CYCLES = srs_pkg::HOLD_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        standby_rail_ok,
	input  wire logic        main_rail_ok,
	output var  logic        standby_rail_reset_n,
	input  wire logic        main_rail_reset_n_in,
	output var  logic        main_rail_reset_n_out,
	output var  logic        main_rail_reset_n_oe_n,
	input  wire logic        int_request,
	output var  logic        int_n_out,
	output var  logic        int_n_oe_n,
	input  wire logic        pwm_duty_in,
	output var  logic        pwm_out,
	output var  logic        pwm_oe_n,
	output var  logic        vref_sel_2v5,
	output var  logic        diode2_analog_mode,
	input  wire logic        diode1_cathode_test_strap,
	input  wire logic        test_tree_result,
	output var  logic        test_tree_out,
	output var  logic        test_tree_oe_n
);
	logic [31:0]        config_reg;
	logic [31:0]        test1_reg;
	logic [31:0]        analog_cfg_reg;
	logic               ext_rst_seen_reg;
	logic               standby_rel;
	logic               main_rel;
	logic               main_run;
	logic               ext_rst_req;
	logic               wr_en;
	logic               rd_en;
	logic               mapped;
	logic [31:0]        status_word;
	logic [31:0]        rdata_next;
	srs_pkg::srs_strap_t strap_reg;

	// Standby reset timer.
	// (RULE_04) hold while rail low
	// (RULE_05) hold interval release
	srs_hold_timer #(
		.HOLD_CYCLES (HOLD_CYCLES),
		.CNT_W       (srs_pkg::HOLD_CNT_W)
	) u_standby_timer (
		.pclk        (pclk),
		.presetn     (presetn),
		.ce          (ce),
		.run         (standby_rail_ok),
		.release_reg (standby_rel)
	);

	// The pin reads back low while we drive it, so the request only counts when released.
	// (RULE_09) external reset request
	assign ext_rst_req = !main_rail_reset_n_in && main_rail_reset_n_oe_n;

	// Counting waits for the standby release, which orders main after standby.
	// (RULE_06) hold while rail low
	// (RULE_08) ordered after standby
	assign main_run = main_rail_ok && standby_rel && !ext_rst_req;

	// (RULE_07) hold interval release
	srs_hold_timer #(
		.HOLD_CYCLES (HOLD_CYCLES),
		.CNT_W       (srs_pkg::HOLD_CNT_W)
	) u_main_timer (
		.pclk        (pclk),
		.presetn     (presetn),
		.ce          (ce),
		.run         (main_run),
		.release_reg (main_rel)
	);

	assign standby_rail_reset_n = standby_rel;

	// (RULE_06) drive pin low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_rail_reset_n_oe_n <= 1'b0;
			main_rail_reset_n_out  <= 1'b0;
		end else if (ce) begin
			main_rail_reset_n_oe_n <= main_rel && !ext_rst_req;
			main_rail_reset_n_out  <= 1'b0;
		end
	end

	// APB slave with no wait states; pready comes from a flop.
	assign mapped = (paddr[31:srs_pkg::ADDR_W] == '0) && (paddr[1:0] == 2'b00);
	assign wr_en  = psel && penable && pready && pwrite && mapped;
	assign rd_en  = psel && !penable && !pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready  <= psel && !penable && !pready;
			pslverr <= psel && !penable && !pready && !mapped;
		end
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[srs_pkg::ST_STBY_REL_BIT]  = standby_rel;
		status_word[srs_pkg::ST_MAIN_REL_BIT]  = main_rel;
		status_word[srs_pkg::ST_TEST_MODE_BIT] = (strap_reg == srs_pkg::SRS_STRAP_TEST);
		status_word[srs_pkg::ST_EXT_RST_BIT]   = ext_rst_seen_reg;
		status_word[srs_pkg::ST_STBY_OK_BIT]   = standby_rail_ok;
		status_word[srs_pkg::ST_MAIN_OK_BIT]   = main_rail_ok;
	end

	always_comb begin
		rdata_next = 32'h0000_0000;
		if (mapped) begin
			case (paddr[srs_pkg::ADDR_W-1:0])
				srs_pkg::OFF_CONFIG:     rdata_next = config_reg;
				srs_pkg::OFF_TEST1:      rdata_next = test1_reg;
				srs_pkg::OFF_ANALOG_CFG: rdata_next = analog_cfg_reg;
				srs_pkg::OFF_STATUS:     rdata_next = status_word;
				default:                 rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			if (rd_en) begin
				prdata <= rdata_next;
			end
		end
	end

	// Only the documented bits are kept; the rest read as zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_reg <= srs_pkg::CONFIG_RST;
		end else if (ce) begin
			if (wr_en && paddr[srs_pkg::ADDR_W-1:0] == srs_pkg::OFF_CONFIG) begin
				config_reg <= 32'h0000_0000;
				config_reg[srs_pkg::CFG_INT_EN_BIT] <= pwdata[srs_pkg::CFG_INT_EN_BIT];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test1_reg <= srs_pkg::TEST1_RST;
		end else if (ce) begin
			if (wr_en && paddr[srs_pkg::ADDR_W-1:0] == srs_pkg::OFF_TEST1) begin
				test1_reg <= 32'h0000_0000;
				test1_reg[srs_pkg::TEST1_PWM_INV_BIT] <= pwdata[srs_pkg::TEST1_PWM_INV_BIT];
			end
		end
	end

	// (RULE_10) reference select
	// (RULE_12) second diode mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog_cfg_reg <= srs_pkg::ANALOG_CFG_RST;
		end else if (ce) begin
			if (wr_en && paddr[srs_pkg::ADDR_W-1:0] == srs_pkg::OFF_ANALOG_CFG) begin
				analog_cfg_reg <= 32'h0000_0000;
				analog_cfg_reg[srs_pkg::ACFG_VREF_2V5_BIT] <=
					pwdata[srs_pkg::ACFG_VREF_2V5_BIT];
				analog_cfg_reg[srs_pkg::ACFG_D2_ANALOG_BIT] <=
					pwdata[srs_pkg::ACFG_D2_ANALOG_BIT];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vref_sel_2v5       <= 1'b0;
			diode2_analog_mode <= 1'b0;
		end else if (ce) begin
			vref_sel_2v5       <= analog_cfg_reg[srs_pkg::ACFG_VREF_2V5_BIT];
			diode2_analog_mode <= analog_cfg_reg[srs_pkg::ACFG_D2_ANALOG_BIT];
		end
	end

	// Sticky external reset flag; a new request wins over a write-one clear.
	// (RULE_09) record external request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_rst_seen_reg <= 1'b0;
		end else if (ce) begin
			if (ext_rst_req) begin
				ext_rst_seen_reg <= 1'b1;
			end else if (wr_en && paddr[srs_pkg::ADDR_W-1:0] == srs_pkg::OFF_STATUS &&
			             pwdata[srs_pkg::ST_EXT_RST_BIT]) begin
				ext_rst_seen_reg <= 1'b0;
			end
		end
	end

	// (RULE_01) gated interrupt drive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_n_oe_n <= 1'b1;
			int_n_out  <= 1'b0;
		end else if (ce) begin
			int_n_oe_n <= !(config_reg[srs_pkg::CFG_INT_EN_BIT] && int_request);
			int_n_out  <= 1'b0;
		end
	end

	// Open drain: a high level is the released pin pulled up.
	// (RULE_02) high after reset
	// (RULE_03) polarity inversion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_oe_n <= srs_pkg::PWM_LEVEL_RST;
			pwm_out  <= 1'b0;
		end else if (ce) begin
			pwm_oe_n <= pwm_duty_in ^ test1_reg[srs_pkg::TEST1_PWM_INV_BIT];
			pwm_out  <= 1'b0;
		end
	end

	// The strap is caught at the first enabled edge after release, never under reset.
	// (RULE_11) power-on strap sample
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_reg <= srs_pkg::SRS_STRAP_WAIT;
		end else if (ce) begin
			case (strap_reg)
				srs_pkg::SRS_STRAP_WAIT: begin
					strap_reg <= diode1_cathode_test_strap ? srs_pkg::SRS_STRAP_TEST
					                                       : srs_pkg::SRS_STRAP_NORM;
				end
				srs_pkg::SRS_STRAP_NORM: strap_reg <= srs_pkg::SRS_STRAP_NORM;
				srs_pkg::SRS_STRAP_TEST: strap_reg <= srs_pkg::SRS_STRAP_TEST;
				default:                 strap_reg <= srs_pkg::SRS_STRAP_WAIT;
			endcase
		end
	end

	// Outside test mode the pin stays an address input, so it is not driven.
	// (RULE_13) test result output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_tree_out  <= 1'b0;
			test_tree_oe_n <= 1'b1;
		end else if (ce) begin
			test_tree_out  <= (strap_reg == srs_pkg::SRS_STRAP_TEST) && test_tree_result;
			test_tree_oe_n <= (strap_reg != srs_pkg::SRS_STRAP_TEST);
		end
	end
endmodule : srs_supervisor
`default_nettype wire

// ===== testbench/srs_sup_assertions.sv
// Purpose: Port checks of srs_supervisor reset timing and pin control.
// Assumes: ce is held high, so every clock edge counts.
// Notes:   Counters rebuild the hold timers from the ports; the main count also uses the reset outputs.
`timescale 1ns/100ps
`default_nettype none
module srs_sup_assertions #(
	parameter int unsigned HOLD_CYCLES = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic standby_rail_ok,
	input wire logic main_rail_ok,
	input wire logic standby_rail_reset_n,
	input wire logic main_rail_reset_n_in,
	input wire logic main_rail_reset_n_oe_n,
	input wire logic int_request,
	input wire logic int_n_oe_n,
	input wire logic test_tree_result,
	input wire logic test_tree_out,
	input wire logic test_tree_oe_n
);
	int unsigned s_cnt;
	int unsigned m_cnt;
	logic        m_run;
	// A low pin seen while released is an outside request, so it stops the count.
	assign m_run = main_rail_ok && standby_rail_reset_n
		&& !(main_rail_reset_n_oe_n && !main_rail_reset_n_in);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) s_cnt <= 0;
		else s_cnt <= standby_rail_ok ? s_cnt + 1 : 0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) m_cnt <= 0;
		else m_cnt <= m_run ? m_cnt + 1 : 0;
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_int_needs_req: assert property (!int_request |=> int_n_oe_n)
		else $error("Interrupt driven without request.");
	a_stby_low: assert property (!standby_rail_ok |=> !standby_rail_reset_n)
		else $error("Standby reset released with rail low.");
	a_stby_hold_len: assert property (
		$rose(standby_rail_reset_n) |-> s_cnt == HOLD_CYCLES)
		else $error("Standby hold length wrong.");
	a_main_low: assert property (
		!main_rail_ok |=> ##1 !main_rail_reset_n_oe_n)
		else $error("Main reset released with rail low.");
	a_main_hold_len: assert property (
		$rose(main_rail_reset_n_oe_n) |-> $past(m_cnt) == HOLD_CYCLES)
		else $error("Main hold length wrong.");
	a_main_after_stby: assert property (
		!standby_rail_reset_n [*2] |=> !main_rail_reset_n_oe_n)
		else $error("Main reset released before standby.");
	a_ext_req_taken: assert property (
		main_rail_reset_n_oe_n && !main_rail_reset_n_in |=> !main_rail_reset_n_oe_n)
		else $error("External reset request ignored.");
	a_tree_follows: assert property (
		!test_tree_oe_n && !$past(test_tree_oe_n) |-> test_tree_out == $past(test_tree_result))
		else $error("Test tree output wrong.");
endmodule : srs_sup_assertions
bind srs_supervisor srs_sup_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (.pclk, .presetn,
	.standby_rail_ok, .main_rail_ok, .standby_rail_reset_n, .main_rail_reset_n_in,
	.main_rail_reset_n_oe_n, .int_request, .int_n_oe_n, .test_tree_result, .test_tree_out,
	.test_tree_oe_n);
`default_nettype wire

// ===== testbench/srs_board_model.sv
// Purpose: Board side of the main reset pin: pull-up and outside reset.
// Assumes: Any low driver wins over the pull-up.
// Notes:   The pin reads high only when nobody pulls it low.
`timescale 1ns/100ps
`default_nettype none
module srs_board_model (
	input  wire logic main_rail_reset_n_out,
	input  wire logic main_rail_reset_n_oe_n,
	input  wire logic ext_pull,
	output var  logic main_pin
);
	assign main_pin = (main_rail_reset_n_oe_n | main_rail_reset_n_out) & !ext_pull;
endmodule : srs_board_model
`default_nettype wire

// ===== testbench/srs_supervisor_tb.sv
// Purpose: Directed bench for srs_supervisor over APB and its pins.
// Assumes: HOLD shortens the 180 ms hold; ce stays high.
// Notes:   Hold counts start at the edge after each rail recovers.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
$display("Error %s expected %0h seen %0h", n, e, g); end end
module srs_supervisor_tb;
	localparam int unsigned HOLD = 20;
	logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
	logic standby_rail_ok = 1'b0, main_rail_ok = 1'b0, int_request = 1'b0, pwm_duty_in = 1'b0;
	logic diode1_cathode_test_strap = 1'b1, test_tree_result = 1'b0, ext_pull = 1'b0, err;
	logic pready, pslverr, standby_rail_reset_n, main_rail_reset_n_in, main_rail_reset_n_out;
	logic main_rail_reset_n_oe_n, int_n_out, int_n_oe_n, pwm_out, pwm_oe_n, vref_sel_2v5;
	logic diode2_analog_mode, test_tree_out, test_tree_oe_n;
	int failures = 0, comparisons = 0, n, ts;
	srs_supervisor #(.HOLD_CYCLES(HOLD)) uut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .standby_rail_ok, .main_rail_ok,
		.standby_rail_reset_n, .main_rail_reset_n_in, .main_rail_reset_n_out,
		.main_rail_reset_n_oe_n, .int_request, .int_n_out, .int_n_oe_n, .pwm_duty_in, .pwm_out,
		.pwm_oe_n, .vref_sel_2v5, .diode2_analog_mode, .diode1_cathode_test_strap,
		.test_tree_result, .test_tree_out, .test_tree_oe_n);
	srs_board_model board (.main_rail_reset_n_out, .main_rail_reset_n_oe_n, .ext_pull,
		.main_pin(main_rail_reset_n_in));
	task automatic stop_test();
		$display("Comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait; the slave alone decides when it answers.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rchk(input logic [31:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0);
		`CHK("prdata", e, rd)
		`CHK("pslverr", ee, err)
	endtask : rchk
	// Kind 0 drops standby, 1 drops main, 2 pulls the main pin low, each for one edge.
	task automatic blip(input int kind);
		@(posedge pclk);
		if (kind == 0) standby_rail_ok <= 1'b0;
		else if (kind == 1) main_rail_ok <= 1'b0;
		else ext_pull <= 1'b1;
		@(posedge pclk);
		standby_rail_ok <= 1'b1;
		main_rail_ok <= 1'b1;
		ext_pull <= 1'b0;
		#1;
		if (kind == 0) `CHK("stby_drop", 1'b0, standby_rail_reset_n)
	endtask : blip
	task automatic count_rel(input int exp_n, input int exp_ts);
		n = 0;
		ts = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
			if (standby_rail_reset_n === 1'b1 && ts == 0) ts = n;
		// A standby drop pulls main down a few edges late, so main only counts after standby.
		end while ((main_rail_reset_n_in !== 1'b1 || ts == 0) && n < 500);
		`CHK("main_hold", exp_n, n)
		`CHK("stby_hold", exp_ts, ts)
	endtask : count_rel
	initial begin
		forever #5 pclk = ~pclk;
	end
	initial begin
		#200_000;
		failures++;
		stop_test();
	end
	initial begin
		repeat (20) @(posedge pclk);
		`CHK("stby_rst", 1'b0, standby_rail_reset_n)
		`CHK("main_rst", 1'b0, main_rail_reset_n_in)
		`CHK("int_oe_n", 1'b1, int_n_oe_n)
		`CHK("pwm_pin", 1'b1, pwm_oe_n)
		`CHK("vref", 1'b0, vref_sel_2v5)
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		diode1_cathode_test_strap <= 1'b0;
		test_tree_result <= 1'b1;
		repeat (2) @(posedge pclk);
		`CHK("tree", 2'b01, {test_tree_oe_n, test_tree_out})
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		`CHK("tree_oe_n", 1'b1, test_tree_oe_n)
		rchk(32'h0, 32'h0, 1'b0);
		rchk(32'h10, 32'h0, 1'b1);
		apb(1'b1, 32'h8, 32'hffff_ffff);
		rchk(32'h8, 32'h3, 1'b0);
		`CHK("vref_d2", 2'b11, {vref_sel_2v5, diode2_analog_mode})
		int_request <= 1'b1;
		pwm_duty_in <= 1'b1;
		repeat (2) @(posedge pclk);
		`CHK("int_dis", 1'b1, int_n_oe_n)
		`CHK("pwm_nmos", 1'b1, pwm_oe_n)
		apb(1'b1, 32'h0, 32'hffff_ffff);
		rchk(32'h0, 32'h2, 1'b0);
		`CHK("int_en", 1'b0, int_n_oe_n)
		apb(1'b1, 32'h4, 32'hffff_ffff);
		rchk(32'h4, 32'h2, 1'b0);
		`CHK("pwm_pmos", 1'b0, pwm_oe_n)
		int_request <= 1'b0;
		pwm_duty_in <= 1'b0;
		repeat (2) @(posedge pclk);
		`CHK("int_idle", 1'b1, int_n_oe_n)
		`CHK("pwm_pmos", 1'b1, pwm_oe_n)
		standby_rail_ok <= 1'b1;
		main_rail_ok <= 1'b1;
		count_rel(2 * HOLD + 1, HOLD);
		rchk(32'hc, 32'h33, 1'b0);
		blip(1);
		repeat (8) @(posedge pclk);
		blip(1);
		count_rel(HOLD + 1, 1);
		blip(0);
		count_rel(2 * HOLD + 1, HOLD);
		blip(2);
		count_rel(HOLD + 1, 1);
		rchk(32'hc, 32'h3b, 1'b0);
		apb(1'b1, 32'hc, 32'h8);
		rchk(32'hc, 32'h33, 1'b0);
		`CHK("od_low", 3'b000, {main_rail_reset_n_out, int_n_out, pwm_out})
		stop_test();
	end
endmodule : srs_supervisor_tb
`default_nettype wire
